/* File: hdl/hotplug_slot_ctrl_status.sv */
// slot control and slot status register pair of a downstream port
`timescale 1ns/1ps
// Contract
// RULE_01: pair decodes at 80h, downstream only
// RULE_02: bit 0 enables button-pressed event
// RULE_03: bit 1 enables power fault event
// RULE_04: bit 2 enables latch sensor change
// RULE_05: bit 3 enables presence change event
// RULE_06: bit 4 command-completed, unless no-support cap
// RULE_07: bit 5 master interrupt enable
// RULE_08: bits 7:6 attention indicator, write sends message
// RULE_09: bits 9:8 power indicator, strap-based reset
// RULE_10: bit 10 slot power off, strap-based reset
// RULE_11: bit 11 enables interlock event
// RULE_12: bit 12 enables link state change
// RULE_13: bits 16-19 sticky, write one clears
// RULE_14: bit 20 command completed, write one clears
// RULE_15: bit 21 live latch sensor state
// RULE_16: bit 22 live card presence
// RULE_17: no slot implemented, presence reads one
// RULE_18: bit 23 live interlock state
// RULE_19: bit 24 sets on link-active change
// RULE_20: link-active input follows active state
// RULE_21: capability bit 18 blocks command interrupt
// RULE_22: interrupt is master and enabled flags
// RULE_23: reserved bits read zero, ignore writes
module hotplug_slot_ctrl_status
  import hp_slot_pkg::*;
#(
  parameter bit DOWNSTREAM = 1'b1
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_ack,
  input  wire logic        i_cap_mrl_present,
  input  wire logic        i_cap_no_cmd_cpl,
  input  wire logic        i_slot_implemented,
  input  wire logic        i_dl_active,
  input  wire logic        i_cmd_done,
  input  wire logic        i_attn_button,
  input  wire logic        i_power_fault,
  input  wire logic        i_mrl_open,
  input  wire logic        i_presence,
  input  wire logic        i_electromech_interlock,
  output logic      [1:0]  o_attn_ind,
  output logic      [1:0]  o_pwr_ind,
  output logic             o_pwr_off,
  output logic             o_attn_msg,
  output logic             o_pwr_msg,
  output logic             o_cmd_issued,
  output logic             o_hp_int,
  output logic             o_wake
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [CTL_W-1:0]  ctrl_q;
  logic              init_q;
  logic [PIN_W-1:0]  pins;
  logic [PIN_W-1:0]  pins_q;
  logic              dl_q;
  logic              hit;
  logic              wr_hit;
  logic              rd_hit;
  logic [FLG_W-1:0]  flg_set;
  logic [FLG_W-1:0]  flg_clr;
  logic [FLG_W-1:0]  flags;
  logic [FLG_W-1:0]  flg_en;
  logic              ilk_evt;
  logic              presence_rd;
  logic [31:0]       rd_word;
  logic              cmd_en;

  // ************************************************************
  // decode
  // ************************************************************
  // RULE_01: downstream-only decode
  assign hit    = DOWNSTREAM && (i_cfg_addr == SLOT_REG_OFFSET);
  assign wr_hit = i_cfg_wr && hit && init_q;
  assign rd_hit = i_cfg_rd && hit;

  // ************************************************************
  // slot pin synchronisers
  // ************************************************************
  hp_pin_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     ({i_electromech_interlock, i_presence, i_mrl_open,
                 i_power_fault, i_attn_button}),
    .o_level   (pins)
  );

  // RULE_20: link-active level sampled
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_q <= '0;
      dl_q   <= 1'b0;
    end else begin
      pins_q <= pins;
      dl_q   <= i_dl_active;
    end
  end

  // ************************************************************
  // slot control register
  // ************************************************************
  // RULE_09: strap picks power indicator reset
  // RULE_10: strap picks power controller reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q <= 1'b0;
      ctrl_q <= '0;
    end else if (!init_q) begin
      init_q                             <= 1'b1;
      ctrl_q                             <= '0;
      ctrl_q[CTL_ATTN_LO+1:CTL_ATTN_LO]  <= ATTN_RST;
      ctrl_q[CTL_PWRI_LO+1:CTL_PWRI_LO]  <= i_cap_mrl_present ?
                                            IND_OFF : IND_ON;
      ctrl_q[CTL_PWR_OFF]                <= i_cap_mrl_present;
    end else if (wr_hit) begin
      // RULE_23: only implemented bits take writes
      if (i_cfg_be[0]) begin
        ctrl_q[7:0] <= i_cfg_wdata[7:0];
      end
      if (i_cfg_be[1]) begin
        ctrl_q[CTL_W-1:8] <= i_cfg_wdata[CTL_W-1:8];
      end
    end
  end

  // RULE_08: attention write sends message
  // RULE_09: power indicator write sends message
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_attn_msg   <= 1'b0;
      o_pwr_msg    <= 1'b0;
      o_cmd_issued <= 1'b0;
    end else begin
      o_attn_msg   <= wr_hit && i_cfg_be[0];
      o_pwr_msg    <= wr_hit && i_cfg_be[1];
      o_cmd_issued <= wr_hit && (i_cfg_be[0] || i_cfg_be[1]);
    end
  end

  // RULE_08: attention indicator drive
  assign o_attn_ind = ctrl_q[CTL_ATTN_LO+1:CTL_ATTN_LO];
  // RULE_09: power indicator drive
  assign o_pwr_ind  = ctrl_q[CTL_PWRI_LO+1:CTL_PWRI_LO];
  // RULE_10: one turns slot power off
  assign o_pwr_off  = ctrl_q[CTL_PWR_OFF];

  // ************************************************************
  // event flags
  // ************************************************************
  // RULE_13: button, fault, latch, presence events
  assign flg_set[FLG_ABP]   = pins[PIN_ABP] && !pins_q[PIN_ABP];
  assign flg_set[FLG_PF]    = pins[PIN_PF] && !pins_q[PIN_PF];
  assign flg_set[FLG_MRLC]  = pins[PIN_MRL] ^ pins_q[PIN_MRL];
  assign flg_set[FLG_PDC]   = pins[PIN_PRES] ^ pins_q[PIN_PRES];
  // RULE_14: command completion latches
  assign flg_set[FLG_CC]    = i_cmd_done;
  // RULE_19: link-active change either way
  assign flg_set[FLG_DLLSC] = i_dl_active ^ dl_q;
  assign ilk_evt            = pins[PIN_ILK] ^ pins_q[PIN_ILK];

  // RULE_13: write one clears sticky flags
  assign flg_clr[FLG_ABP]   = wr_hit && i_cfg_be[2] && i_cfg_wdata[STS_ABP];
  assign flg_clr[FLG_PF]    = wr_hit && i_cfg_be[2] && i_cfg_wdata[STS_PF];
  assign flg_clr[FLG_MRLC]  = wr_hit && i_cfg_be[2] && i_cfg_wdata[STS_MRLC];
  assign flg_clr[FLG_PDC]   = wr_hit && i_cfg_be[2] && i_cfg_wdata[STS_PDC];
  assign flg_clr[FLG_CC]    = wr_hit && i_cfg_be[2] && i_cfg_wdata[STS_CC];
  assign flg_clr[FLG_DLLSC] = wr_hit && i_cfg_be[3] &&
                              i_cfg_wdata[STS_DLLSC];

  hp_sticky_flags #(
    .W (FLG_W)
  ) u_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (flg_set),
    .i_clr     (flg_clr),
    .o_flags   (flags)
  );

  // ************************************************************
  // interrupt and wakeup
  // ************************************************************
  // RULE_06: command interrupt needs support
  // RULE_21: capability bit blocks command path
  assign cmd_en = ctrl_q[CTL_CC_EN] && !i_cap_no_cmd_cpl;

  // RULE_02: button enable
  // RULE_03: fault enable
  // RULE_04: latch sensor enable
  // RULE_05: presence enable
  // RULE_12: link state enable
  assign flg_en = {ctrl_q[CTL_DLL_EN], cmd_en, ctrl_q[CTL_PDC_EN],
                   ctrl_q[CTL_MRL_EN], ctrl_q[CTL_PF_EN],
                   ctrl_q[CTL_ABP_EN]};

  // RULE_07: master enable gates interrupt
  // RULE_22: level until flags cleared
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hp_int <= 1'b0;
    end else begin
      o_hp_int <= ctrl_q[CTL_HPI_EN] && (|(flags & flg_en));
    end
  end

  // RULE_11: interlock event enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= (|(flg_set & flg_en & ~(FLG_W'(1) << FLG_CC))) ||
                (ilk_evt && ctrl_q[CTL_ILK_EN]);
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // RULE_16: live presence
  // RULE_17: no slot reads present
  assign presence_rd = i_slot_implemented ? pins[PIN_PRES] : 1'b1;

  // RULE_15: live latch sensor state
  // RULE_18: live interlock state
  // RULE_23: reserved read zero
  always_comb begin
    rd_word                        = 32'h0000_0000;
    rd_word[CTL_W-1:0]             = ctrl_q;
    rd_word[STS_ABP]               = flags[FLG_ABP];
    rd_word[STS_PF]                = flags[FLG_PF];
    rd_word[STS_MRLC]              = flags[FLG_MRLC];
    rd_word[STS_PDC]               = flags[FLG_PDC];
    rd_word[STS_CC]                = flags[FLG_CC];
    rd_word[STS_MRL]               = pins[PIN_MRL];
    rd_word[STS_PRES]              = presence_rd;
    rd_word[STS_ILK]               = pins[PIN_ILK];
    rd_word[STS_DLLSC]             = flags[FLG_DLLSC];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_ack   <= 1'b0;
    end else begin
      o_cfg_rdata <= rd_hit ? rd_word : 32'h0000_0000;
      o_cfg_ack   <= i_cfg_rd || i_cfg_wr;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_lo;
    wr_hit && i_cfg_be[0];
  endsequence
  sequence s_wr_hi;
    wr_hit && i_cfg_be[1];
  endsequence

  property p_attn_msg;
    s_wr_lo |=> o_attn_msg && (o_attn_ind == $past(i_cfg_wdata[7:6]));
  endproperty
  a_attn_msg: assert property (p_attn_msg) // RULE_08
    else $error("attention write did not send message");
  property p_pwr_msg;
    s_wr_hi |=> o_pwr_msg && (o_pwr_off == $past(i_cfg_wdata[10])) &&
                (o_pwr_ind == $past(i_cfg_wdata[9:8]));
  endproperty
  a_pwr_msg: assert property (p_pwr_msg) // RULE_09
    else $error("power write did not send message");
  property p_int_on;
    (ctrl_q[CTL_HPI_EN] && |(flags & flg_en)) |=> o_hp_int;
  endproperty
  a_int_on: assert property (p_int_on) // RULE_22
    else $error("enabled flag did not raise interrupt");
  property p_int_master;
    !ctrl_q[CTL_HPI_EN] |=> !o_hp_int;
  endproperty
  a_int_master: assert property (p_int_master) // RULE_07
    else $error("interrupt without master enable");
  property p_cc_blocked;
    (i_cap_no_cmd_cpl && !(|(flags & flg_en & 6'h2F))) |=> !o_hp_int;
  endproperty
  a_cc_blocked: assert property (p_cc_blocked) // RULE_21
    else $error("command interrupt despite no-support cap");
  property p_dll_set;
    $changed(i_dl_active) |=> flags[FLG_DLLSC];
  endproperty
  a_dll_set: assert property (p_dll_set) // RULE_19
    else $error("link change not latched");
  property p_abp_clear;
    (flg_clr[FLG_ABP] && !flg_set[FLG_ABP]) |=> !flags[FLG_ABP];
  endproperty
  a_abp_clear: assert property (p_abp_clear) // RULE_13
    else $error("button flag not cleared by write one");
  property p_sticky;
    (flags[FLG_CC] && !flg_clr[FLG_CC]) |=> flags[FLG_CC];
  endproperty
  a_sticky: assert property (p_sticky) // RULE_14
    else $error("command flag lost without clear");
  property p_rsvd;
    o_cfg_ack |-> (o_cfg_rdata[15:13] == 3'h0) &&
                  (o_cfg_rdata[31:25] == 7'h00);
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE_23
    else $error("reserved bits read nonzero");
  property p_no_slot;
    (rd_hit && !i_slot_implemented) |=> o_cfg_rdata[STS_PRES];
  endproperty
  a_no_slot: assert property (p_no_slot) // RULE_17
    else $error("presence not one without slot");
  property p_unmapped;
    (i_cfg_rd && !hit) |=> o_cfg_ack && (o_cfg_rdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE_01
    else $error("unmapped read returned data");

endmodule

/* File: hdl/hp_pin_sync.sv */
// three-stage synchroniser with agreement filter for slot pins
`timescale 1ns/1ps
module hp_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level moves only where stages two and three agree
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= '0;
    end else begin
      o_level <= (o_level & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end
  end

endmodule

/* File: hdl/hp_slot_pkg.sv */
// constants for the hot-plug slot control and status register pair
package hp_slot_pkg;

  // ************************************************************
  // register location
  // ************************************************************
  localparam logic [7:0] SLOT_REG_OFFSET = 8'h80;

  // ************************************************************
  // slot control field positions
  // ************************************************************
  localparam int CTL_ABP_EN   = 0;
  localparam int CTL_PF_EN    = 1;
  localparam int CTL_MRL_EN   = 2;
  localparam int CTL_PDC_EN   = 3;
  localparam int CTL_CC_EN    = 4;
  localparam int CTL_HPI_EN   = 5;
  localparam int CTL_ATTN_LO  = 6;
  localparam int CTL_PWRI_LO  = 8;
  localparam int CTL_PWR_OFF  = 10;
  localparam int CTL_ILK_EN   = 11;
  localparam int CTL_DLL_EN   = 12;
  localparam int CTL_W        = 13;

  // ************************************************************
  // slot status field positions
  // ************************************************************
  localparam int STS_ABP      = 16;
  localparam int STS_PF       = 17;
  localparam int STS_MRLC     = 18;
  localparam int STS_PDC      = 19;
  localparam int STS_CC       = 20;
  localparam int STS_MRL      = 21;
  localparam int STS_PRES     = 22;
  localparam int STS_ILK      = 23;
  localparam int STS_DLLSC    = 24;

  // ************************************************************
  // sticky flag indices and pin indices
  // ************************************************************
  localparam int FLG_ABP      = 0;
  localparam int FLG_PF       = 1;
  localparam int FLG_MRLC     = 2;
  localparam int FLG_PDC      = 3;
  localparam int FLG_CC       = 4;
  localparam int FLG_DLLSC    = 5;
  localparam int FLG_W        = 6;
  localparam int PIN_ABP      = 0;
  localparam int PIN_PF       = 1;
  localparam int PIN_MRL      = 2;
  localparam int PIN_PRES     = 3;
  localparam int PIN_ILK      = 4;
  localparam int PIN_W        = 5;

  // ************************************************************
  // indicator encodings and reset values
  // ************************************************************
  localparam logic [1:0] IND_ON    = 2'h1;
  localparam logic [1:0] IND_BLINK = 2'h2;
  localparam logic [1:0] IND_OFF   = 2'h3;
  localparam logic [1:0] ATTN_RST  = IND_OFF;

endpackage

/* File: hdl/hp_sticky_flags.sv */
// write-one-to-clear event flags where a set beats a clear
`timescale 1ns/1ps
module hp_sticky_flags #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_flags
);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flags <= '0;
    end else begin
      o_flags <= (o_flags & ~i_clr) | i_set;
    end
  end

endmodule

/* File: testbench/hotplug_slot_ctrl_status_bench.sv */
// self-checking bench for the slot control and status pair
`timescale 1ns/1ps
module hotplug_slot_ctrl_status_bench;
  import hp_slot_pkg::*;
  logic        i_ref_clk;
  logic        i_rst_n;
  logic        i_cfg_wr;
  logic        i_cfg_rd;
  logic [7:0]  i_cfg_addr;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata;
  logic [31:0] o_cfg_rdata;
  logic        o_cfg_ack;
  logic        i_cap_mrl_present;
  logic        i_cap_no_cmd_cpl;
  logic        i_slot_implemented;
  logic        i_dl_active;
  logic        i_cmd_done;
  logic [1:0]  o_attn_ind;
  logic [1:0]  o_pwr_ind;
  logic        o_pwr_off;
  logic        o_attn_msg;
  logic        o_pwr_msg;
  logic        o_cmd_issued;
  logic        o_hp_int;
  logic        o_wake;
  logic [4:0]  pin_req;
  logic [4:0]  pins;
  logic [3:0]  cpl_delay;
  logic [31:0] rd;
  logic [2:0]  msg;
  int          n_errors;
  int          tests_run;
  int          wakes;

  hotplug_slot_ctrl_status dut (
    .i_ref_clk, .i_rst_n, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_be,
    .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack, .i_cap_mrl_present,
    .i_cap_no_cmd_cpl, .i_slot_implemented, .i_dl_active, .i_cmd_done,
    .i_attn_button           (pins[PIN_ABP]),
    .i_power_fault           (pins[PIN_PF]),
    .i_mrl_open              (pins[PIN_MRL]),
    .i_presence              (pins[PIN_PRES]),
    .i_electromech_interlock (pins[PIN_ILK]),
    .o_attn_ind, .o_pwr_ind, .o_pwr_off, .o_attn_msg, .o_pwr_msg,
    .o_cmd_issued, .o_hp_int, .o_wake
  );

  hp_slot_model slot (
    .i_ref_clk, .i_rst_n,
    .i_cmd_issued (o_cmd_issued),
    .i_cpl_delay  (cpl_delay),
    .i_pin_req    (pin_req),
    .o_pins       (pins),
    .o_cmd_done   (i_cmd_done)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (o_wake === 1'b1) wakes <= wakes + 1;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic cfg(input logic wr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(negedge i_ref_clk);
    i_cfg_wr    = wr;
    i_cfg_rd    = !wr;
    i_cfg_addr  = a;
    i_cfg_be    = be;
    i_cfg_wdata = d;
    @(negedge i_ref_clk);
    i_cfg_wr = 1'b0;
    i_cfg_rd = 1'b0;
    rd       = o_cfg_rdata;
    msg      = {o_attn_msg, o_pwr_msg, o_cmd_issued};
    check({31'h0, o_cfg_ack}, 32'h1);
  endtask

  task automatic rdchk(input logic [31:0] exp);
    cfg(1'b0, SLOT_REG_OFFSET, 4'hF, 32'h0);
    check(rd, exp);
  endtask

  task automatic w1c(input logic [31:0] d);
    cfg(1'b1, SLOT_REG_OFFSET, 4'hC, d);
  endtask

  // control write, then drop its command-completed flag
  task automatic wctl(input logic [15:0] d);
    cfg(1'b1, SLOT_REG_OFFSET, 4'h3, {16'h0, d});
    cyc(18);
    w1c(32'h0010_0000);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset(input logic strap, input logic [31:0] exp);
    i_cap_mrl_present = strap;
    i_rst_n           = 1'b0;
    cyc(3);
    i_rst_n = 1'b1;
    cyc(2);
    rdchk(exp);
    check({29'h0, o_pwr_off, o_pwr_ind}, {29'h0, exp[10:8]});
    check({30'h0, o_attn_ind}, 32'h3);
  endtask

  task automatic t_ctrl();
    cpl_delay = 4'h0;
    cfg(1'b1, SLOT_REG_OFFSET, 4'hF, 32'hFFFF_FFFF);
    check({29'h0, msg}, 32'h7);
    cyc(4);
    rdchk(32'h0010_1FFF);
    check({31'h0, o_hp_int}, 32'h1);
    w1c(32'h0010_0000);
    cyc(2);
    check({31'h0, o_hp_int}, 32'h0);
    i_cap_no_cmd_cpl = 1'b1;
    cpl_delay        = 4'h9;
    cfg(1'b1, SLOT_REG_OFFSET, 4'h1, 32'h0000_003F);
    check({29'h0, msg}, 32'h5);
    cyc(14);
    rdchk(32'h0010_1F3F);
    check({31'h0, o_hp_int}, 32'h0);
    i_cap_no_cmd_cpl = 1'b0;
    w1c(32'h0010_0000);
  endtask

  task automatic t_ind();
    for (int c = 1; c < 4; c++) begin
      cfg(1'b1, SLOT_REG_OFFSET, 4'h1, 32'(c << 6));
      check({29'h0, msg}, 32'h5);
      check({30'h0, o_attn_ind}, 32'(c));
      cfg(1'b1, SLOT_REG_OFFSET, 4'h2, 32'((c << 8) | ((c & 1) << 10)));
      check({29'h0, msg}, 32'h3);
      check({29'h0, o_pwr_off, o_pwr_ind}, 32'(c | ((c & 1) << 2)));
    end
    cyc(12);
    w1c(32'h0010_0000);
  endtask

  task automatic t_event(input int i);
    logic [31:0] live;
    int          w;
    live = (i == PIN_MRL) ? 32'h0020_0000 :
           (i == PIN_PRES) ? 32'h0040_0000 : 32'h0;
    wctl(16'h0020);
    w          = wakes;
    pin_req[i] = 1'b1;
    cyc(10);
    rdchk(live | (32'h1 << (STS_ABP + i)) | 32'h20);
    check({31'h0, o_hp_int}, 32'h0);
    check(32'(wakes - w), 32'h0);
    wctl(16'h0020 | (16'h1 << i));
    cyc(2);
    check({31'h0, o_hp_int}, 32'h1);
    w1c(32'h1 << (STS_ABP + i));
    cyc(2);
    check({31'h0, o_hp_int}, 32'h0);
    w          = wakes;
    pin_req[i] = 1'b0;
    cyc(10);
    check({31'h0, o_hp_int}, 32'(i >= PIN_MRL));
    check(32'(wakes - w), 32'(i >= PIN_MRL));
    w1c(32'h001F_0000);
  endtask

  task automatic t_ilk();
    int w;
    wctl(16'h0800);
    w                = wakes;
    pin_req[PIN_ILK] = 1'b1;
    cyc(10);
    rdchk(32'h0080_0800);
    check(32'(wakes - w), 32'h1);
    check({31'h0, o_hp_int}, 32'h0);
    pin_req[PIN_ILK]   = 1'b0;
    i_slot_implemented = 1'b0;
    cyc(10);
    rdchk(32'h0040_0800);
    i_slot_implemented = 1'b1;
  endtask

  task automatic t_dll();
    int w;
    wctl(16'h1000);
    w           = wakes;
    i_dl_active = 1'b1;
    cyc(3);
    rdchk(32'h0100_1000);
    check({31'h0, o_hp_int}, 32'h0);
    check(32'(wakes - w), 32'h1);
    wctl(16'h1020);
    check({31'h0, o_hp_int}, 32'h1);
    w1c(32'h0100_0000);
    i_dl_active = 1'b0;
    cyc(3);
    rdchk(32'h0100_1020);
    w1c(32'h0100_0000);
    cyc(2);
    check({31'h0, o_hp_int}, 32'h0);
  endtask

  task automatic t_unmap();
    cfg(1'b1, 8'h84, 4'hF, 32'hFFFF_FFFF);
    check({29'h0, msg}, 32'h0);
    cfg(1'b0, 8'h84, 4'hF, 32'h0);
    check(rd, 32'h0);
    rdchk(32'h0000_1020);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    #2_000_000;
    n_errors++;
    end_of_test();
  end

  initial begin
    i_rst_n            = 1'b0;
    i_cfg_wr           = 1'b0;
    i_cfg_rd           = 1'b0;
    i_cfg_addr         = 8'h00;
    i_cfg_be           = 4'h0;
    i_cfg_wdata        = 32'h0;
    i_cap_mrl_present  = 1'b1;
    i_cap_no_cmd_cpl   = 1'b0;
    i_slot_implemented = 1'b1;
    i_dl_active        = 1'b0;
    pin_req            = 5'h00;
    cpl_delay          = 4'h3;
    t_reset(1'b1, 32'h0000_07C0);
    t_reset(1'b0, 32'h0000_01C0);
    t_ctrl();
    t_ind();
    t_event(0);
    t_event(1);
    t_event(2);
    t_event(3);
    t_ilk();
    t_dll();
    t_unmap();
    end_of_test();
  end
endmodule

/* File: testbench/hp_slot_model.sv */
// slot hardware model: switch pins and hot-plug controller completion
`timescale 1ns/1ps
module hp_slot_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cmd_issued,
  input  wire logic [3:0] i_cpl_delay,
  input  wire logic [4:0] i_pin_req,
  output logic      [4:0] o_pins,
  output logic            o_cmd_done
);
  int cnt;

  // ************************************************************
  // pins move off the clock, like real switches
  // ************************************************************
  initial o_pins = 5'h00;
  always @(i_pin_req) begin
    o_pins <= #7 i_pin_req;
  end

  // ************************************************************
  // command completion after a chosen delay
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt        <= 0;
      o_cmd_done <= 1'b0;
    end else begin
      o_cmd_done <= (cnt == 1);
      if (i_cmd_issued) begin
        cnt <= int'(i_cpl_delay) + 1;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
